// ==== rtl/tfrc_defs.vh ====
// Constants of the exposure trigger and frame rate limit register bank.
// Assumes byte offsets on the camera's register port and documented bit n
// mapping to vector index 31-n (bit 0 is the most significant bit).
`ifndef TFRC_DEFS_VH
`define TFRC_DEFS_VH

// Register byte offsets.
`define TFRC_ADDR_W            12
`define TFRC_OFS_TRIG          12'h830
`define TFRC_OFS_RATE          12'h83C

// Common feature fields.
`define TFRC_PRESENCE_BIT      31
`define TFRC_ABS_BIT           30
`define TFRC_ONE_PUSH_BIT      26
`define TFRC_ON_OFF_BIT        25
`define TFRC_AUTO_BIT          24

// Trigger register fields.
`define TFRC_POL_BIT           24
`define TFRC_SRC_HI            23
`define TFRC_SRC_LO            21
`define TFRC_MODE_HI           19
`define TFRC_MODE_LO           16

// Frame rate register fields.
`define TFRC_VAL_HI            11
`define TFRC_VAL_LO            0

// Reset values.
`define TFRC_RST_TRIG_ON       1'b0
`define TFRC_RST_POL           1'b1
`define TFRC_RST_SRC           3'h0
`define TFRC_RST_MODE          4'h0
`define TFRC_RST_RATE_ON       1'b0
`define TFRC_RST_RATE_VAL      12'hFFF

// Field encodings.
`define TFRC_SRC_PORT3         3'h3
`define TFRC_SRC_SOFT          3'h7
`define TFRC_MODE_PROG         4'h0
`define TFRC_MODE_LEVEL        4'h1
`define TFRC_RATE_MIN          12'h001

`endif

// ==== rtl/tfrc_trig_sel.v ====
// Trigger origin selector and edge sense for the exposure trigger.
// Assumes trigger pins and the software strobe are synchronous to ref_clk.
`timescale 1ns/1ps
`include "tfrc_defs.vh"

module tfrc_trig_sel #(
  parameter N_PORTS = 4
) (
  input  wire               ref_clk,
  input  wire               arst_n,
  input  wire               trig_on,
  input  wire               trig_pol,
  input  wire [2:0]         trig_src,
  input  wire [3:0]         trig_mode,
  input  wire [N_PORTS-1:0] trig_pin,
  input  wire               soft_trig,
  output reg                exp_start,
  output reg                exp_level
);

  reg  active_d;
  wire hw_sel;
  wire pin_raw;
  wire pin_act;

  //////////////////////////////////////////////////////////////////////////
  // (RL2) origin selection
  assign hw_sel  = (trig_src <= `TFRC_SRC_PORT3);
  assign pin_raw = hw_sel ? trig_pin[trig_src[1:0]] : 1'b0;
  // (RL1) (RL15) edge sense
  // The sense is applied only to a pin; the software strobe is always taken as active high.
  assign pin_act = hw_sel & ~(pin_raw ^ trig_pol);

  //////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_d  <= 1'b0;
      exp_start <= 1'b0;
      exp_level <= 1'b0;
    end else begin
      active_d <= pin_act;
      // (RL14) trigger on/off
      if (!trig_on) begin
        exp_start <= 1'b0;
        exp_level <= 1'b0;
      end else if (trig_src == `TFRC_SRC_SOFT) begin
        // (RL4) soft is programmable
        exp_start <= soft_trig;
        exp_level <= 1'b0;
      end else begin
        exp_start <= pin_act & ~active_d;
        // (RL3) level mode exposure
        exp_level <= (trig_mode == `TFRC_MODE_LEVEL) & pin_act;
      end
    end
  end

endmodule

// ==== rtl/tfrc_regs.v ====
// Exposure trigger control and frame rate limit feature registers.
// Assumes a register port already decoded from the camera's serial bus:
// one-cycle read and write strobes carrying a byte offset and a quadlet.
//
// Overview of operation
// (RL1) Edge sense 0 means pin active low, 1 active high; resets to 1.
// (RL2) Origin field codes 0..3 pick pins 0..3, code 7 software; resets 0.
// (RL3) Behaviour field 0 is programmable, 1 is level exposure; resets 0.
// (RL4) Software must use programmable behaviour with the software origin.
// (RL5) Software ignores trigger bits 11, 16..19 and 20..31.
// (RL6) Frame rate presence bit always reads 1, read-only.
// (RL7) Frame rate absolute-control bit always reads 0, read-only.
// (RL8) Frame rate single-shot adjust bit always reads 0, read-only.
// (RL9) Frame rate enable resets 0; limit acts only in scalable format.
// (RL10) Frame rate auto bit always reads 0, meaning manual control.
// (RL11) Frame rate value 1..4095 in tenths of fps; resets to 4095.
// (RL12) Programmed rate applies only when below the constraint rate.
// (RL13) Value writes are taken only while the enable bit is 1.
// (RL14) Trigger on/off bit switches triggered exposure; resets 0.
// (RL15) Edge sense applies only to a hardware pin origin.
// (RL16) Out-of-range settings raise a feature error; capture goes on.
// (RL17) Writes to read-only and reserved fields are ignored.
`timescale 1ns/1ps
`include "tfrc_defs.vh"

module tfrc_regs #(
  parameter N_PORTS = 4,
  parameter RATE_W  = 12
) (
  input  wire                    ref_clk,
  input  wire                    arst_n,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  input  wire [`TFRC_ADDR_W-1:0] reg_addr,
  input  wire [31:0]             reg_wdata,
  output reg  [31:0]             reg_rdata,
  output reg                     reg_rvalid,
  output reg                     reg_wack,
  input  wire                    fmt_scalable,
  input  wire [RATE_W-1:0]       constraint_rate,
  input  wire [N_PORTS-1:0]      trig_pin,
  input  wire                    soft_trig,
  output wire                    exp_start,
  output wire                    exp_level,
  output reg  [RATE_W-1:0]       eff_rate,
  output reg                     rate_limited,
  output reg                     trig_err,
  output reg                     rate_err
);

  //////////////////////////////////////////////////////////////////////////
  // Stored fields.

  reg               trig_on;
  reg               trig_pol;
  reg  [2:0]        trig_src;
  reg  [3:0]        trig_mode;
  reg               rate_on;
  reg  [RATE_W-1:0] rate_val;

  wire              hit_trig;
  wire              hit_rate;
  wire              wr_trig;
  wire              wr_rate;
  wire [2:0]        w_src;
  wire [3:0]        w_mode;
  wire [RATE_W-1:0] w_val;
  wire              w_rate_on;
  reg  [31:0]       next_rdata;
  reg  [RATE_W-1:0] next_eff_rate;
  reg               next_rate_limited;

  //////////////////////////////////////////////////////////////////////////
  // Range checks, shared by the error flags.

  // A source code 4..6 names no origin; level behaviour needs a pin.
  function trig_bad;
    input [2:0] src;
    input [3:0] mode;
    begin
      trig_bad = ((src > `TFRC_SRC_PORT3) && (src != `TFRC_SRC_SOFT)) ||
                 (mode > `TFRC_MODE_LEVEL) ||
                 ((src == `TFRC_SRC_SOFT) && (mode != `TFRC_MODE_PROG));
    end
  endfunction

  function rate_bad;
    input [RATE_W-1:0] val;
    begin
      rate_bad = (val < `TFRC_RATE_MIN);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Address decode.

  assign hit_trig  = (reg_addr == `TFRC_OFS_TRIG);
  assign hit_rate  = (reg_addr == `TFRC_OFS_RATE);
  assign wr_trig   = reg_wr & hit_trig;
  assign wr_rate   = reg_wr & hit_rate;
  assign w_src     = reg_wdata[`TFRC_SRC_HI:`TFRC_SRC_LO];
  assign w_mode    = reg_wdata[`TFRC_MODE_HI:`TFRC_MODE_LO];
  assign w_val     = reg_wdata[`TFRC_VAL_HI:`TFRC_VAL_LO];
  assign w_rate_on = reg_wdata[`TFRC_ON_OFF_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Trigger register writes.

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      // (RL14) trigger off reset
      trig_on   <= `TFRC_RST_TRIG_ON;
      // (RL1) sense reset high
      trig_pol  <= `TFRC_RST_POL;
      // (RL2) origin reset port0
      trig_src  <= `TFRC_RST_SRC;
      // (RL3) behaviour reset programmable
      trig_mode <= `TFRC_RST_MODE;
    end else if (wr_trig) begin
      // (RL17) only writable fields stored
      // Bits 11 and 16..31 are dropped here, so they always read zero.
      trig_on   <= reg_wdata[`TFRC_ON_OFF_BIT];
      trig_pol  <= reg_wdata[`TFRC_POL_BIT];
      trig_src  <= w_src;
      trig_mode <= w_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame rate register writes.

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      // (RL9) enable reset zero
      rate_on  <= `TFRC_RST_RATE_ON;
      // (RL11) value reset 4095
      rate_val <= `TFRC_RST_RATE_VAL;
    end else if (wr_rate) begin
      // (RL9) enable bit write
      rate_on <= w_rate_on;
      // (RL13) value gated by enable
      // The enable carried in the same quadlet decides, so one write can
      // both switch the limit on and load its value.
      if (w_rate_on) begin
        rate_val <= w_val;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data.

  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit_trig) begin
      next_rdata[`TFRC_PRESENCE_BIT]            = 1'b1;
      next_rdata[`TFRC_ON_OFF_BIT]              = trig_on;
      next_rdata[`TFRC_POL_BIT]                 = trig_pol;
      next_rdata[`TFRC_SRC_HI:`TFRC_SRC_LO]     = trig_src;
      next_rdata[`TFRC_MODE_HI:`TFRC_MODE_LO]   = trig_mode;
    end else if (hit_rate) begin
      // (RL6) presence reads one
      next_rdata[`TFRC_PRESENCE_BIT]            = 1'b1;
      // (RL7) abs control zero
      next_rdata[`TFRC_ABS_BIT]                 = 1'b0;
      // (RL8) one push zero
      next_rdata[`TFRC_ONE_PUSH_BIT]            = 1'b0;
      next_rdata[`TFRC_ON_OFF_BIT]              = rate_on;
      // (RL10) manual mode only
      next_rdata[`TFRC_AUTO_BIT]                = 1'b0;
      next_rdata[`TFRC_VAL_HI:`TFRC_VAL_LO]     = rate_val;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
      reg_wack   <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_wack   <= reg_wr;
      // Data holds between reads so a slow bus side may sample it late.
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Effective frame rate.

  always @* begin
    next_eff_rate     = constraint_rate;
    next_rate_limited = 1'b0;
    // (RL9) limit in scalable format
    // (RL12) lower rate governs
    if (rate_on && fmt_scalable && (rate_val < constraint_rate)) begin
      next_eff_rate     = rate_val;
      next_rate_limited = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      eff_rate     <= {RATE_W{1'b0}};
      rate_limited <= 1'b0;
    end else begin
      eff_rate     <= next_eff_rate;
      rate_limited <= next_rate_limited;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Feature error flags.

  // The flags are registered from the stored settings, so each one changes
  // one cycle after a register is written and clears one cycle after a legal setting is stored.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_err <= 1'b0;
      rate_err <= 1'b0;
    end else begin
      // (RL16) range error flags
      // (RL4) soft needs programmable
      trig_err <= trig_bad(trig_src, trig_mode);
      rate_err <= rate_bad(rate_val);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Trigger path.

  // (RL16) capture continues on error
  // An out-of-range setting is still passed on; the selector simply finds
  // no pin for an unused origin code.
  tfrc_trig_sel #(
    .N_PORTS (N_PORTS)
  ) u_trig_sel (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .trig_on   (trig_on),
    .trig_pol  (trig_pol),
    .trig_src  (trig_src),
    .trig_mode (trig_mode),
    .trig_pin  (trig_pin),
    .soft_trig (soft_trig),
    .exp_start (exp_start),
    .exp_level (exp_level)
  );

endmodule

// ==== tb/tfrc_monitor.sv ====
// Checker for the trigger and frame rate register bank.
// Assumes binding to tfrc_regs and its one clock domain.
`timescale 1ns/1ps
module tfrc_monitor (
  input wire        ref_clk,
  input wire        arst_n,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire        reg_rvalid,
  input wire        reg_wack,
  input wire        fmt_scalable,
  input wire [11:0] constraint_rate,
  input wire        exp_start,
  input wire [11:0] eff_rate,
  input wire        rate_limited,
  input wire        trig_err,
  input wire        rate_err
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire wr_trig = reg_wr && reg_addr == 12'h830;
  wire wr_rate = reg_wr && reg_addr == 12'h83C;
  ////////////////////////////////////////
  property p_rvalid; reg_rd |=> reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read unanswered");
  property p_wack; reg_wr |=> reg_wack; endproperty
  a_wack: assert property (p_wack) else $error("write unanswered");
  property p_tfix;
    reg_rd && reg_addr == 12'h830 |=> reg_rdata[31:26] == 6'h20;
  endproperty
  a_tfix: assert property (p_tfix)
    else $error("trigger fixed bits wrong");
  property p_rfix;
    reg_rd && reg_addr == 12'h83C |=>
      {reg_rdata[31:26], reg_rdata[24:12]} == 19'h40000;
  endproperty
  a_rfix: assert property (p_rfix)
    else $error("frame rate fixed bits wrong");
  property p_terr;
    wr_trig && reg_wdata[23] && reg_wdata[22:21] != 2'b11 |-> ##2 trig_err;
  endproperty
  a_terr: assert property (p_terr)
    else $error("bad origin not flagged");
  property p_rerr;
    wr_rate && reg_wdata[25] && reg_wdata[11:0] == 12'h000 |-> ##2 rate_err;
  endproperty
  a_rerr: assert property (p_rerr)
    else $error("zero rate not flagged");
  property p_lim;
    rate_limited |-> $past(fmt_scalable) && eff_rate < $past(constraint_rate);
  endproperty
  a_lim: assert property (p_lim)
    else $error("limit active wrongly");
  property p_eff;
    !rate_limited && $past(arst_n) |-> eff_rate == $past(constraint_rate);
  endproperty
  a_eff: assert property (p_eff)
    else $error("constraint rate not governing");
  c_lim: cover property (rate_limited);
  c_exp: cover property (exp_start);
  c_err: cover property (trig_err);
  c_rerr: cover property (rate_err);
endmodule

bind tfrc_regs tfrc_monitor u_mon (
  .ref_clk(ref_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .reg_wack(reg_wack),
  .fmt_scalable(fmt_scalable), .constraint_rate(constraint_rate),
  .exp_start(exp_start), .eff_rate(eff_rate), .rate_limited(rate_limited),
  .trig_err(trig_err), .rate_err(rate_err)
);

// ==== tb/test_trigger_and_frame_rate_control.sv ====
// Self-checking bench for the trigger and frame rate register bank.
// Assumes tfrc_regs with its default widths and offsets.
`timescale 1ns/1ps
`include "tfrc_defs.vh"
module test_trigger_and_frame_rate_control;
  reg         ref_clk = 1'b0;
  reg         arst_n = 1'b0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [11:0] reg_addr = 12'h000;
  reg  [31:0] reg_wdata = 32'h00000000;
  reg         fmt_scalable = 1'b1;
  reg  [11:0] constraint_rate = 12'h0C8;
  reg  [3:0]  trig_pin = 4'h0;
  reg         soft_trig = 1'b0;
  wire [31:0] reg_rdata;
  wire [11:0] eff_rate;
  wire        reg_rvalid, reg_wack, exp_start, exp_level;
  wire        rate_limited, trig_err, rate_err;
  integer     n_mismatch = 0;
  integer     num_checks = 0;
  integer     p;
  tfrc_regs dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_wack(reg_wack),
    .fmt_scalable(fmt_scalable), .constraint_rate(constraint_rate),
    .trig_pin(trig_pin), .soft_trig(soft_trig), .exp_start(exp_start),
    .exp_level(exp_level), .eff_rate(eff_rate),
    .rate_limited(rate_limited), .trig_err(trig_err), .rate_err(rate_err)
  );
  ////////////////////////////////////////
  task check(input string nm, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task complete_run;
    begin
      if (n_mismatch == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task tick;
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      // One idle edge first, so a strobe is never dropped and raised again
      // in the same time step by two accesses in a row.
      tick;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
      check("wack", 32'h1, reg_wack);
    end
  endtask
  task rd(input [11:0] a, input [31:0] e, input [31:0] m);
    begin
      tick;
      reg_addr = a;
      reg_rd = 1'b1;
      tick;
      reg_rd = 1'b0;
      check("rvalid", 32'h1, reg_rvalid);
      check("rdata", e & m, reg_rdata & m);
    end
  endtask
  // Counting pulses over a window avoids pinning the exact start cycle.
  task watch(input integer n, input lv);
    integer k, c;
    begin
      c = 0;
      for (k = 0; k < 4; k = k + 1) begin
        tick;
        soft_trig = 1'b0;
        if (exp_start === 1'b1) c = c + 1;
      end
      if (n >= 0) check("starts", n, c);
      check("level", {31'h0, lv}, exp_level);
    end
  endtask
  task pin(input [3:0] v, input integer n, input lv);
    begin
      trig_pin = v;
      watch(n, lv);
    end
  endtask
  function [31:0] tcfg(input on, input pol, input [2:0] s, input [3:0] m);
    tcfg = {6'h00, on, pol, s, 1'b0, m, 16'h0000};
  endfunction
  ////////////////////////////////////////
  task t_reset;
    begin
      rd(`TFRC_OFS_TRIG, 32'h81000000, 32'hFFFFFFFF);
      rd(`TFRC_OFS_RATE, 32'h80000FFF, 32'hFFFFFFFF);
      rd(12'h840, 32'h00000000, 32'hFFFFFFFF);
    end
  endtask
  task t_rate;
    begin
      wr(`TFRC_OFS_RATE, 32'h00000064);
      rd(`TFRC_OFS_RATE, 32'h80000FFF, 32'hFFFFFFFF);
      wr(`TFRC_OFS_RATE, 32'h02000064);
      rd(`TFRC_OFS_RATE, 32'h82000064, 32'hFFFFFFFF);
      check("limited", 32'h1, rate_limited);
      check("eff", 32'h064, eff_rate);
      fmt_scalable = 1'b0;
      tick;
      tick;
      check("limited", 32'h0, rate_limited);
      fmt_scalable = 1'b1;
      wr(`TFRC_OFS_RATE, 32'h020000C8);
      tick;
      check("eff", 32'h0C8, eff_rate);
      wr(`TFRC_OFS_RATE, 32'hFFFFFFFF);
      rd(`TFRC_OFS_RATE, 32'h82000FFF, 32'hFFFFFFFF);
      wr(`TFRC_OFS_RATE, 32'h02000000);
      tick;
      check("rate_err", 32'h1, rate_err);
      wr(`TFRC_OFS_RATE, 32'h02000001);
      tick;
      check("rate_err", 32'h0, rate_err);
    end
  endtask
  task t_trig;
    begin
      for (p = 0; p < 4; p = p + 1) begin
        wr(`TFRC_OFS_TRIG, tcfg(1'b1, 1'b1, p[2:0], 4'h0));
        pin(4'h1 << ((p + 1) % 4), 0, 1'b0);
        pin(4'h0, 0, 1'b0);
        pin(4'h1 << p, 1, 1'b0);
        pin(4'h0, 0, 1'b0);
      end
      // Pins go high only once active low sense is stored, so the old
      // setting cannot leave the edge detector already armed.
      wr(`TFRC_OFS_TRIG, tcfg(1'b1, 1'b0, 3'h2, 4'h0));
      pin(4'hF, 0, 1'b0);
      pin(4'hB, 1, 1'b0);
      pin(4'hF, 0, 1'b0);
      trig_pin = 4'h0;
      wr(`TFRC_OFS_TRIG, tcfg(1'b1, 1'b1, 3'h1, 4'h1));
      pin(4'h2, -1, 1'b1);
      pin(4'h0, -1, 1'b0);
      wr(`TFRC_OFS_TRIG, tcfg(1'b1, 1'b0, 3'h7, 4'h0));
      soft_trig = 1'b1;
      watch(1, 1'b0);
      wr(`TFRC_OFS_TRIG, tcfg(1'b1, 1'b1, 3'h7, 4'h1));
      tick;
      check("trig_err", 32'h1, trig_err);
      wr(`TFRC_OFS_TRIG, tcfg(1'b1, 1'b1, 3'h5, 4'h0));
      soft_trig = 1'b1;
      watch(0, 1'b0);
      wr(`TFRC_OFS_TRIG, tcfg(1'b0, 1'b1, 3'h0, 4'h0));
      pin(4'h1, 0, 1'b0);
      wr(`TFRC_OFS_TRIG, 32'hFFFFFFFF);
      rd(`TFRC_OFS_TRIG, 32'h83EF0000, 32'hFFEFF000);
    end
  endtask
  ////////////////////////////////////////
  initial forever #5 ref_clk = ~ref_clk;
  // About 160 cycles are needed; over a hundred times that means a hang.
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    t_reset;
    t_rate;
    t_trig;
    complete_run;
  end
endmodule
